/* rtrs_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the touch result/status bank
// Assumes: Byte-wide register port behind the serial protocol layer
// Notes: Definitions only; included by bare name
`ifndef RTRS_DEFS_SVH
`define RTRS_DEFS_SVH

// Register byte addresses on the register port
`define RTRS_ADDR_STATUS2 8'h00
`define RTRS_ADDR_X_HIGH 8'h01
`define RTRS_ADDR_X_LOW 8'h02
`define RTRS_ADDR_Y_HIGH 8'h03
`define RTRS_ADDR_Y_LOW 8'h04
`define RTRS_ADDR_P_HIGH 8'h05
`define RTRS_ADDR_P_LOW 8'h06

// Second status register field positions
`define RTRS_CAL_BIT 7
`define RTRS_RSVD_BIT 6
`define RTRS_ZOOM_BIT 5
`define RTRS_ROT_BIT 4
`define RTRS_SLIDE_MSB 3
`define RTRS_SLIDE_LSB 2
`define RTRS_TYPE_MSB 1
`define RTRS_TYPE_LSB 0

// Reset and fixed values
`define RTRS_RSVD_VALUE 1'b0
`define RTRS_COORD_RESET 16'h0000
`define RTRS_BYTE_RESET 8'h00
`define RTRS_UNMAPPED_DATA 8'h00

// Timing
`define RTRS_CLK_PERIOD_NS 100
`define RTRS_PROBE_SETTLE_NS 50000
`define RTRS_PROBE_SETTLE_CYC ((`RTRS_PROBE_SETTLE_NS + `RTRS_CLK_PERIOD_NS - 1) / `RTRS_CLK_PERIOD_NS)
`define RTRS_PROBE_CNT_W 10
`define RTRS_NVM_TIMEOUT_NS 1000000
`define RTRS_NVM_TIMEOUT_CYC (`RTRS_NVM_TIMEOUT_NS / `RTRS_CLK_PERIOD_NS)
`define RTRS_NVM_CNT_W 14

`endif

/* rtrs_pkg.sv */
// Purpose: Types shared by the touch result/status bank
// Assumes: Nothing beyond the defs header
// Notes: Encodings of screen type and slide direction follow the status field
package rtrs_pkg;

  typedef enum logic [1:0] {
    RTRS_SCREEN_NONE = 2'b00,
    RTRS_SCREEN_FOUR = 2'b01,
    RTRS_SCREEN_FIVE = 2'b10
  } rtrs_screen_e;

  typedef enum logic [1:0] {
    RTRS_SLIDE_HPOS = 2'b00,
    RTRS_SLIDE_HNEG = 2'b01,
    RTRS_SLIDE_VPOS = 2'b10,
    RTRS_SLIDE_VNEG = 2'b11
  } rtrs_slide_e;

  typedef enum logic [1:0] {
    RTRS_PR_START = 2'b00,
    RTRS_PR_SETTLE = 2'b01,
    RTRS_PR_SAMPLE = 2'b10,
    RTRS_PR_DONE = 2'b11
  } rtrs_probe_state_e;

  typedef enum logic [1:0] {
    RTRS_CAL_LOAD_REQ = 2'b00,
    RTRS_CAL_LOAD_WAIT = 2'b01,
    RTRS_CAL_RUN = 2'b10
  } rtrs_cal_state_e;

endpackage

/* rtrs_pin_sync.sv */
// Purpose: Three-stage synchroniser for a pin input
// Assumes: Pin is asynchronous to clk_sys
// Notes: Output follows only when the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module rtrs_pin_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pin and result
  input wire logic pinIn,
  output logic level_ff
);

  logic stage1_ff;
  logic stage2_ff;
  logic stage3_ff;
  logic nxt_level;

  // Accept a change only once two settled stages agree; filters a single-cycle glitch
  always_comb begin
    nxt_level = level_ff;
    if (stage2_ff == stage3_ff) begin
      nxt_level = stage3_ff;
    end
  end

  // Stage one feeds stage two only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
      stage3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      level_ff <= nxt_level;
    end
  end

endmodule // rtrs_pin_sync
`default_nettype wire

/* rtrs_screen_probe.sv */
// Purpose: Probe the attached resistive screen once after every reset
// Assumes: Sense inputs are already synchronised
// Notes: Both senses high is resolved to four-wire so the reserved code never appears
`timescale 1ns/1ps
`default_nettype none
`include "rtrs_defs.svh"
module rtrs_screen_probe
  import rtrs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Synchronised sense lines
  input wire logic fourSense,
  input wire logic fiveSense,
  // Probe control and result
  output logic drive_ff,
  output logic done_ff,
  output logic [1:0] screenType_ff
);

  localparam logic [`RTRS_PROBE_CNT_W-1:0] SettleLast = `RTRS_PROBE_CNT_W'(`RTRS_PROBE_SETTLE_CYC - 1);

  rtrs_probe_state_e state_ff;
  rtrs_probe_state_e nxt_state;
  logic [`RTRS_PROBE_CNT_W-1:0] cnt_ff;
  logic [`RTRS_PROBE_CNT_W-1:0] nxt_cnt;
  logic nxt_drive;
  logic nxt_done;
  logic [1:0] nxt_screenType;

  // Probe sequence: drive, let the screen settle, sample, then hold the result
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_drive = drive_ff;
    nxt_done = done_ff;
    nxt_screenType = screenType_ff;
    case (state_ff)
      RTRS_PR_START: begin
        nxt_drive = 1'b1;
        nxt_cnt = '0;
        nxt_state = RTRS_PR_SETTLE;
      end
      RTRS_PR_SETTLE: begin
        if (cnt_ff == SettleLast) begin
          nxt_state = RTRS_PR_SAMPLE;
        end else begin
          nxt_cnt = cnt_ff + `RTRS_PROBE_CNT_W'(1);
        end
      end
      RTRS_PR_SAMPLE: begin
        // Four-wire wins a tie: the reserved code must never be produced
        if (fourSense) begin
          nxt_screenType = RTRS_SCREEN_FOUR;
        end else if (fiveSense) begin
          nxt_screenType = RTRS_SCREEN_FIVE;
        end else begin
          nxt_screenType = RTRS_SCREEN_NONE;
        end
        nxt_drive = 1'b0;
        nxt_done = 1'b1;
        nxt_state = RTRS_PR_DONE;
      end
      RTRS_PR_DONE: begin
        nxt_state = RTRS_PR_DONE;
      end
      default: begin
        nxt_state = RTRS_PR_START;
      end
    endcase
  end

  // Reset restarts the probe, so it runs after every reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff <= RTRS_PR_START;
      cnt_ff <= '0;
      drive_ff <= 1'b0;
      done_ff <= 1'b0;
      screenType_ff <= RTRS_SCREEN_NONE;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      drive_ff <= nxt_drive;
      done_ff <= nxt_done;
      screenType_ff <= nxt_screenType;
    end
  end

endmodule // rtrs_screen_probe
`default_nettype wire

/* rtrs_status_regs.sv */
// Purpose: Read-only result and status bank of a resistive touch controller
// Assumes: Serial protocol layer presents one-cycle byte read/write strobes
// Notes: Every register here is read-only; any write to one of them draws an invalid-write answer
`timescale 1ns/1ps
`default_nettype none
`include "rtrs_defs.svh"
// What this block does
// - Calibrated flag at status bit 7 sets on successful calibration, clear when uncalibrated.
// - Calibration state kept in persistent storage, restored automatically after reset.
// - Zoom direction at bit 5: zero zoom in, one zoom out.
// - Rotate direction at bit 4: zero clockwise, one counter-clockwise.
// - Slide direction at bits 3-2: horizontal pos/neg, vertical pos/neg.
// - After every reset, probe the screen; type goes in bits 1-0.
// - Type reads 00 none, 01 four-wire, 10 five-wire; 11 never produced.
// - Status bit 6 is reserved and returns a fixed value.
// - X coordinate is 16 bits: high byte 15-8, low byte 7-0.
// - Y coordinate is 16 bits: high byte 15-8, low byte 7-0.
// - Pressure is 16 bits: high byte 15-8, low byte 7-0.
// - All these registers are read-only; writes get an invalid-write answer.
// - Writing a read-only address sets the write error flag.
module rtrs_status_regs
  import rtrs_pkg::*;
#(
  parameter int unsigned NVM_TIMEOUT_CYC = `RTRS_NVM_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port from the serial protocol layer
  input wire logic regRdStb,
  input wire logic regWrStb,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData_ff,
  output logic regAck_ff,
  output logic regWrInvalid_ff,
  output logic regAddrError_ff,
  // Error register link
  input wire logic errFlagClear,
  output logic writeErrorFlag_ff,
  // Processed sample
  input wire logic sampleValid,
  input wire logic [15:0] sampleX,
  input wire logic [15:0] sampleY,
  input wire logic [15:0] samplePressure,
  // Gesture engine results
  input wire logic zoomEvt,
  input wire logic zoomOut,
  input wire logic rotateEvt,
  input wire logic rotateCcw,
  input wire logic slideEvt,
  input wire logic [1:0] slideDir,
  // Calibration engine
  input wire logic calDone,
  input wire logic calLost,
  // Persistent storage
  output logic nvmLoadReq_ff,
  input wire logic nvmLoadDone,
  input wire logic nvmCalValid,
  output logic nvmStoreReq_ff,
  output logic nvmStoreCal_ff,
  // Screen probe pins
  input wire logic senseFourPin,
  input wire logic senseFivePin,
  output logic probeDrive_ff,
  output logic probeDone_ff
);

  localparam logic [`RTRS_NVM_CNT_W-1:0] NvmLast = `RTRS_NVM_CNT_W'(NVM_TIMEOUT_CYC - 1);

  logic fourSync;
  logic fiveSync;
  logic [1:0] screenType;

  // Sense pins come from outside the clock domain
  rtrs_pin_sync u_sync_four (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(senseFourPin),
    .level_ff(fourSync)
  );

  rtrs_pin_sync u_sync_five (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(senseFivePin),
    .level_ff(fiveSync)
  );

  rtrs_screen_probe u_probe (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .fourSense(fourSync),
    .fiveSense(fiveSync),
    .drive_ff(probeDrive_ff),
    .done_ff(probeDone_ff),
    .screenType_ff(screenType)
  );

  // ---------- Calibration flag and persistent storage ----------
  rtrs_cal_state_e calState_ff;
  rtrs_cal_state_e nxt_calState;
  logic calibrated_ff;
  logic nxt_calibrated;
  logic [`RTRS_NVM_CNT_W-1:0] nvmCnt_ff;
  logic [`RTRS_NVM_CNT_W-1:0] nxt_nvmCnt;
  logic nxt_nvmLoadReq;
  logic nxt_nvmStoreReq;
  logic nxt_nvmStoreCal;

  // Restore first; a calibration event wins over the restored value only in the cycle the load answer or timeout lands, earlier ones are overwritten
  always_comb begin
    nxt_calState = calState_ff;
    nxt_calibrated = calibrated_ff;
    nxt_nvmCnt = nvmCnt_ff;
    nxt_nvmLoadReq = 1'b0;
    nxt_nvmStoreReq = 1'b0;
    nxt_nvmStoreCal = nvmStoreCal_ff;
    case (calState_ff)
      RTRS_CAL_LOAD_REQ: begin
        nxt_nvmLoadReq = 1'b1;
        nxt_nvmCnt = '0;
        nxt_calState = RTRS_CAL_LOAD_WAIT;
      end
      RTRS_CAL_LOAD_WAIT: begin
        // A storage that never answers leaves the screen uncalibrated rather than hanging
        if (nvmLoadDone) begin
          nxt_calibrated = nvmCalValid;
          nxt_calState = RTRS_CAL_RUN;
        end else if (nvmCnt_ff == NvmLast) begin
          nxt_calibrated = 1'b0;
          nxt_calState = RTRS_CAL_RUN;
        end else begin
          nxt_nvmCnt = nvmCnt_ff + `RTRS_NVM_CNT_W'(1);
        end
      end
      RTRS_CAL_RUN: begin
        nxt_calState = RTRS_CAL_RUN;
      end
      default: begin
        nxt_calState = RTRS_CAL_LOAD_REQ;
      end
    endcase
    // Success outranks a loss in the same cycle
    if (calDone) begin
      nxt_calibrated = 1'b1;
      nxt_nvmStoreReq = 1'b1;
      nxt_nvmStoreCal = 1'b1;
    end else if (calLost) begin
      nxt_calibrated = 1'b0;
      nxt_nvmStoreReq = 1'b1;
      nxt_nvmStoreCal = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      calState_ff <= RTRS_CAL_LOAD_REQ;
      calibrated_ff <= 1'b0;
      nvmCnt_ff <= '0;
      nvmLoadReq_ff <= 1'b0;
      nvmStoreReq_ff <= 1'b0;
      nvmStoreCal_ff <= 1'b0;
    end else begin
      calState_ff <= nxt_calState;
      calibrated_ff <= nxt_calibrated;
      nvmCnt_ff <= nxt_nvmCnt;
      nvmLoadReq_ff <= nxt_nvmLoadReq;
      nvmStoreReq_ff <= nxt_nvmStoreReq;
      nvmStoreCal_ff <= nxt_nvmStoreCal;
    end
  end

  // ---------- Gesture directions ----------
  logic zoomDir_ff;
  logic nxt_zoomDir;
  logic rotateDir_ff;
  logic nxt_rotateDir;
  logic [1:0] slideDir_ff;
  logic [1:0] nxt_slideDir;

  // Directions hold until the next gesture of the same kind
  always_comb begin
    nxt_zoomDir = zoomEvt ? zoomOut : zoomDir_ff;
    nxt_rotateDir = rotateEvt ? rotateCcw : rotateDir_ff;
    nxt_slideDir = slideEvt ? slideDir : slideDir_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      zoomDir_ff <= 1'b0;
      rotateDir_ff <= 1'b0;
      slideDir_ff <= RTRS_SLIDE_HPOS;
    end else begin
      zoomDir_ff <= nxt_zoomDir;
      rotateDir_ff <= nxt_rotateDir;
      slideDir_ff <= nxt_slideDir;
    end
  end

  // ---------- Coordinate and pressure results ----------
  logic [15:0] xPos_ff;
  logic [15:0] nxt_xPos;
  logic [15:0] yPos_ff;
  logic [15:0] nxt_yPos;
  logic [15:0] press_ff;
  logic [15:0] nxt_press;

  // All three from one sample in one cycle
  always_comb begin
    nxt_xPos = sampleValid ? sampleX : xPos_ff;
    nxt_yPos = sampleValid ? sampleY : yPos_ff;
    nxt_press = sampleValid ? samplePressure : press_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      xPos_ff <= `RTRS_COORD_RESET;
      yPos_ff <= `RTRS_COORD_RESET;
      press_ff <= `RTRS_COORD_RESET;
    end else begin
      xPos_ff <= nxt_xPos;
      yPos_ff <= nxt_yPos;
      press_ff <= nxt_press;
    end
  end

  // ---------- Register port ----------
  logic [7:0] status2;
  logic [7:0] xLowHold_ff;
  logic [7:0] nxt_xLowHold;
  logic [7:0] yLowHold_ff;
  logic [7:0] nxt_yLowHold;
  logic [7:0] pLowHold_ff;
  logic [7:0] nxt_pLowHold;
  logic [2:0] holdValid_ff;
  logic [2:0] nxt_holdValid;
  logic [7:0] nxt_regRdData;
  logic nxt_regAck;
  logic nxt_regWrInvalid;
  logic nxt_regAddrError;
  logic nxt_writeErrorFlag;
  logic addrMapped;

  // Second status register image; bit 6 is a constant
  always_comb begin
    status2 = `RTRS_BYTE_RESET;
    status2[`RTRS_CAL_BIT] = calibrated_ff;
    status2[`RTRS_RSVD_BIT] = `RTRS_RSVD_VALUE;
    status2[`RTRS_ZOOM_BIT] = zoomDir_ff;
    status2[`RTRS_ROT_BIT] = rotateDir_ff;
    status2[`RTRS_SLIDE_MSB:`RTRS_SLIDE_LSB] = slideDir_ff;
    status2[`RTRS_TYPE_MSB:`RTRS_TYPE_LSB] = screenType;
  end

  // Reading a high byte freezes the matching low byte, so a pair never straddles two samples
  always_comb begin
    addrMapped = (regAddr <= `RTRS_ADDR_P_LOW); // Status sits at the bottom of the map
    nxt_regRdData = regRdData_ff;
    nxt_regAck = 1'b0;
    nxt_regWrInvalid = 1'b0;
    nxt_regAddrError = 1'b0;
    nxt_xLowHold = xLowHold_ff;
    nxt_yLowHold = yLowHold_ff;
    nxt_pLowHold = pLowHold_ff;
    nxt_holdValid = holdValid_ff;
    nxt_writeErrorFlag = writeErrorFlag_ff;
    // Clear first so a write in the same cycle sets it again
    if (errFlagClear) begin
      nxt_writeErrorFlag = 1'b0;
    end
    if (regWrStb) begin
      nxt_regAck = 1'b1;
      if (addrMapped) begin
        nxt_regWrInvalid = 1'b1;
        nxt_writeErrorFlag = 1'b1;
      end else begin
        nxt_regAddrError = 1'b1;
      end
    end else if (regRdStb) begin
      nxt_regAck = 1'b1;
      if (regAddr == `RTRS_ADDR_STATUS2) begin
        nxt_regRdData = status2;
      end else if (regAddr == `RTRS_ADDR_X_HIGH) begin
        nxt_regRdData = xPos_ff[15:8];
        nxt_xLowHold = xPos_ff[7:0];
        nxt_holdValid[0] = 1'b1;
      end else if (regAddr == `RTRS_ADDR_X_LOW) begin
        nxt_regRdData = holdValid_ff[0] ? xLowHold_ff : xPos_ff[7:0];
        nxt_holdValid[0] = 1'b0;
      end else if (regAddr == `RTRS_ADDR_Y_HIGH) begin
        nxt_regRdData = yPos_ff[15:8];
        nxt_yLowHold = yPos_ff[7:0];
        nxt_holdValid[1] = 1'b1;
      end else if (regAddr == `RTRS_ADDR_Y_LOW) begin
        nxt_regRdData = holdValid_ff[1] ? yLowHold_ff : yPos_ff[7:0];
        nxt_holdValid[1] = 1'b0;
      end else if (regAddr == `RTRS_ADDR_P_HIGH) begin
        nxt_regRdData = press_ff[15:8];
        nxt_pLowHold = press_ff[7:0];
        nxt_holdValid[2] = 1'b1;
      end else if (regAddr == `RTRS_ADDR_P_LOW) begin
        nxt_regRdData = holdValid_ff[2] ? pLowHold_ff : press_ff[7:0];
        nxt_holdValid[2] = 1'b0;
      end else begin
        nxt_regRdData = `RTRS_UNMAPPED_DATA;
        nxt_regAddrError = 1'b1;
      end
    end
  end

  // Write data is never stored: nothing here is writable
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regRdData_ff <= `RTRS_BYTE_RESET;
      regAck_ff <= 1'b0;
      regWrInvalid_ff <= 1'b0;
      regAddrError_ff <= 1'b0;
      writeErrorFlag_ff <= 1'b0;
      xLowHold_ff <= `RTRS_BYTE_RESET;
      yLowHold_ff <= `RTRS_BYTE_RESET;
      pLowHold_ff <= `RTRS_BYTE_RESET;
      holdValid_ff <= 3'h0;
    end else begin
      regRdData_ff <= nxt_regRdData;
      regAck_ff <= nxt_regAck;
      regWrInvalid_ff <= nxt_regWrInvalid;
      regAddrError_ff <= nxt_regAddrError;
      writeErrorFlag_ff <= nxt_writeErrorFlag;
      xLowHold_ff <= nxt_xLowHold;
      yLowHold_ff <= nxt_yLowHold;
      pLowHold_ff <= nxt_pLowHold;
      holdValid_ff <= nxt_holdValid;
    end
  end

endmodule // rtrs_status_regs
`default_nettype wire

/* rtrs_status_regs_checker.sv */
// Purpose: Port-level assertions for the touch result/status bank
// Assumes: One clock domain, synchronous active-low reset
// Notes: Read answers are judged one cycle after the strobe edge
`timescale 1ns/1ps
`default_nettype none
module rtrs_status_regs_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic regRdStb,
  input wire logic regWrStb,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdData_ff,
  input wire logic regAck_ff,
  input wire logic regWrInvalid_ff,
  input wire logic writeErrorFlag_ff,
  // Sample and calibration
  input wire logic sampleValid,
  input wire logic [15:0] sampleX,
  input wire logic [15:0] samplePressure,
  input wire logic calDone,
  input wire logic calLost,
  input wire logic nvmStoreReq_ff,
  input wire logic nvmStoreCal_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // A read that is taken, then its answer
  sequence rdDone(logic [7:0] a);
    (regRdStb && !regWrStb && regAddr == a) ##1 regAck_ff;
  endsequence

  // A fresh sample followed at once by a read
  sequence smpRd(logic [7:0] a);
    sampleValid ##1 rdDone(a);
  endsequence

  ack_after_req_a: assert property ((regRdStb || regWrStb) |=> regAck_ff)
    else $error("no answer one cycle after a request");
  wr_invalid_map_a: assert property (regWrStb |=> regWrInvalid_ff == ($past(regAddr) <= 8'h06))
    else $error("invalid-write answer does not match the address");
  wr_err_flag_a: assert property (regWrStb && regAddr <= 8'h06 |=> writeErrorFlag_ff)
    else $error("write error flag not set by a read-only write");
  rsvd_bit_a: assert property (rdDone(8'h00) |-> !regRdData_ff[6])
    else $error("reserved status bit not zero");
  type_code_a: assert property (rdDone(8'h00) |-> regRdData_ff[1:0] != 2'b11)
    else $error("reserved screen type code produced");
  x_high_a: assert property (smpRd(8'h01) |-> regRdData_ff == $past(sampleX[15:8], 2))
    else $error("x high byte not from newest sample");
  p_high_a: assert property (smpRd(8'h05) |-> regRdData_ff == $past(samplePressure[15:8], 2))
    else $error("pressure high byte not from newest sample");
  cal_store_set_a: assert property (calDone |=> nvmStoreReq_ff && nvmStoreCal_ff)
    else $error("calibrated state not stored as set");
  cal_store_clr_a: assert property (calLost && !calDone |=> nvmStoreReq_ff && !nvmStoreCal_ff)
    else $error("uncalibrated state not stored as clear");
endmodule // rtrs_status_regs_checker

bind rtrs_status_regs rtrs_status_regs_checker i_rtrs_status_regs_checker (
  .clk_sys, .rst_n, .regRdStb, .regWrStb, .regAddr, .regRdData_ff, .regAck_ff,
  .regWrInvalid_ff, .writeErrorFlag_ff, .sampleValid, .sampleX, .samplePressure,
  .calDone, .calLost, .nvmStoreReq_ff, .nvmStoreCal_ff
);
`default_nettype wire

/* rtrs_nvm_model.sv */
// Purpose: Behavioural persistent storage answering the bank's load and store
// Assumes: Load answer after LAT cycles
// Notes: Stored bit survives reset; valid line is wrong outside the answer
`timescale 1ns/1ps
`default_nettype none
module rtrs_nvm_model #(
  parameter int LAT = 5
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Requests
  input wire logic nvmLoadReq_ff,
  input wire logic nvmStoreReq_ff,
  input wire logic nvmStoreCal_ff,
  // Answers
  output logic nvmLoadDone,
  output logic nvmCalValid
);
  logic stored = 1'b0; // Not cleared by reset, like real storage
  int cnt = 0;
  // Store on request, answer a load after the latency
  always @(posedge clk_sys) begin
    nvmLoadDone <= 1'b0;
    if (nvmStoreReq_ff) stored <= nvmStoreCal_ff;
    if (!rst_n) cnt <= 0;
    else if (nvmLoadReq_ff) cnt <= LAT;
    else if (cnt > 0) begin
      cnt <= cnt - 1;
      nvmLoadDone <= (cnt == 1);
    end
  end
  // Outside the answer the line shows the opposite value
  assign nvmCalValid = nvmLoadDone ? stored : ~stored;
endmodule // rtrs_nvm_model
`default_nettype wire

/* rtrs_status_regs_test.sv */
// Purpose: Self-checking bench for the touch result/status bank
// Assumes: Inputs change at the falling edge; answers one cycle after a strobe
// Notes: Storage timeout shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module rtrs_status_regs_test;
  logic clk_sys, rst_n, regRdStb, regWrStb, errFlagClear, sampleValid, calDone, calLost;
  logic zoomEvt, zoomOut, rotateEvt, rotateCcw, slideEvt, senseFourPin, senseFivePin;
  logic [7:0] regAddr, regWrData, regRdData_ff;
  logic [1:0] slideDir;
  logic [15:0] sampleX, sampleY, samplePressure;
  logic regAck_ff, regWrInvalid_ff, regAddrError_ff, writeErrorFlag_ff, probeDrive_ff, probeDone_ff;
  logic nvmLoadReq_ff, nvmLoadDone, nvmCalValid, nvmStoreReq_ff, nvmStoreCal_ff;
  int errCount = 0;
  int nChecks = 0;
  int cal = 0, zm = 0, rt = 0, sl = 0, ty = 0, ef = 0;
  int cur[3];
  int held[$];
  logic [31:0] seed = 32'd91;

  rtrs_status_regs #(.NVM_TIMEOUT_CYC(20)) i_rtrs_status_regs (
    .clk_sys, .rst_n, .regRdStb, .regWrStb, .regAddr, .regWrData, .regRdData_ff, .regAck_ff,
    .regWrInvalid_ff, .regAddrError_ff, .errFlagClear, .writeErrorFlag_ff, .sampleValid,
    .sampleX, .sampleY, .samplePressure, .zoomEvt, .zoomOut, .rotateEvt, .rotateCcw,
    .slideEvt, .slideDir, .calDone, .calLost, .nvmLoadReq_ff, .nvmLoadDone, .nvmCalValid,
    .nvmStoreReq_ff, .nvmStoreCal_ff, .senseFourPin, .senseFivePin, .probeDrive_ff, .probeDone_ff
  );
  rtrs_nvm_model #(.LAT(5)) i_rtrs_nvm_model (
    .clk_sys, .rst_n, .nvmLoadReq_ff, .nvmStoreReq_ff, .nvmStoreCal_ff, .nvmLoadDone, .nvmCalValid
  );

  // 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected second status byte from the model
  function automatic logic [7:0] st();
    return {cal[0], 1'b0, zm[0], rt[0], sl[1:0], ty[1:0]};
  endfunction

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    nChecks++;
    if (s !== e) begin
      errCount++;
      $display("Error at %0t ns: seen 0x%h expected 0x%h", $time, s, e);
    end
  endtask

  // One read; strobe held over one rising edge, then an idle edge so the next call never re-raises it at once
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    regRdStb = 1'b1;
    regAddr = a;
    @(negedge clk_sys);
    regRdStb = 1'b0;
    chk(8'(regAck_ff), 8'h01);
    chk(regRdData_ff, e);
    chk(8'(regAddrError_ff), 8'(a > 8'h06));
    @(negedge clk_sys);
  endtask

  task automatic smp();
    foreach (cur[i]) cur[i] = int'(xs() & 32'hffff);
    sampleX = cur[0][15:0];
    sampleY = cur[1][15:0];
    samplePressure = cur[2][15:0];
    sampleValid = 1'b1;
    @(negedge clk_sys);
    sampleValid = 1'b0;
  endtask

  // Gesture directions are cleared by reset
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    zm = 0;
    rt = 0;
    sl = 0;
  endtask

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 220 us
  initial begin
    #2000000;
    errCount++;
    giveVerdict();
  end

  initial begin
    {regRdStb, regWrStb, errFlagClear, sampleValid, calDone, calLost} = '0;
    {zoomEvt, zoomOut, rotateEvt, rotateCcw, slideEvt, senseFourPin, senseFivePin} = '0;
    {regAddr, regWrData, slideDir, sampleX, sampleY, samplePressure} = '0;
    rst_n = 1'b0;
    @(negedge clk_sys);
    // Every sense combination; calibration restored across each reset
    for (int k = 0; k < 4; k++) begin
      {senseFivePin, senseFourPin} = 2'(k);
      do_reset();
      @(negedge clk_sys);
      chk(8'(probeDrive_ff), 8'h01);
      repeat (519) @(negedge clk_sys);
      chk(8'({probeDrive_ff, probeDone_ff}), 8'h01);
      ty = k[0] ? 1 : (k[1] ? 2 : 0);
      rd(8'h00, st());
      calDone = k[0];
      calLost = ~k[0];
      @(negedge clk_sys);
      {calDone, calLost} = 2'b00;
      cal = k[0];
      rd(8'h00, st());
    end
    $display("test reset_probe_cal done");
    // Every slide code; directions move only with their event
    for (int i = 0; i < 4; i++) begin
      zm = int'(xs() & 32'h1);
      rt = int'(xs() & 32'h1);
      sl = i;
      {zoomOut, rotateCcw, slideDir} = {zm[0], rt[0], sl[1:0]};
      {zoomEvt, rotateEvt, slideEvt} = 3'b111;
      @(negedge clk_sys);
      {zoomEvt, rotateEvt, slideEvt} = 3'b000;
      {zoomOut, rotateCcw, slideDir} = ~{zm[0], rt[0], sl[1:0]};
      rd(8'h00, st());
    end
    $display("test gestures done");
    // High read holds its low byte across a newer sample
    for (int j = 0; j < 3; j++) begin
      smp();
      rd(8'(2 * j + 1), cur[j][15:8]);
      held.push_back(cur[j]);
      smp();
      rd(8'(2 * j + 2), held[j][7:0]);
    end
    rd(8'h02, cur[0][7:0]);
    $display("test sample_pairing done");
    // Writes: unmapped first, then every read-only register
    for (int a = 7; a >= 0; a--) begin
      regWrStb = 1'b1;
      regAddr = 8'(a);
      regWrData = 8'(xs());
      @(negedge clk_sys);
      regWrStb = 1'b0;
      if (a < 7) ef = 1;
      chk(8'(regWrInvalid_ff), 8'(a < 7));
      chk(8'(regAddrError_ff), 8'(a == 7));
      chk(8'(writeErrorFlag_ff), 8'(ef));
      @(negedge clk_sys);
    end
    errFlagClear = 1'b1;
    @(negedge clk_sys);
    errFlagClear = 1'b0;
    chk(8'(writeErrorFlag_ff), 8'h00);
    rd(8'h00, st());
    rd(8'h01, cur[0][15:8]);
    rd(8'h20, 8'h00);
    chk(8'(regAddrError_ff), 8'h00);
    $display("test writes done");
    giveVerdict();
  end
endmodule // rtrs_status_regs_test
`default_nettype wire
